// ==== hdl/run_halt_wait_ctl.sv ====
// Run/stop flip-flop and T1..T6 cycle sequencer with wait stretching
`include "rhw_cfg.svh"

module run_halt_wait_ctl (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Pins
  input  wire logic               run_stop_toggle_line,
  input  wire logic               wait_n,
  // Instruction sequencer
  input  wire rhw_pkg::core_req_t core_req,
  // Status and strobes
  output rhw_pkg::cyc_state_t     cycle_state,
  output rhw_pkg::bus_ctl_t       bus_ctl,
  output logic                    run_ind,
  output logic                    ifetch,
  output logic                    cycle_end
);

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers and filters

  logic [2:0] sync_run;
  logic [2:0] sync_wait;
  logic       run_filt;
  logic       wait_filt;
  logic [2:0] next_sync_run;
  logic [2:0] next_sync_wait;
  logic       next_run_filt;
  logic       next_wait_filt;
  logic       run_edge;
  logic       wait_low;

  always_comb
  begin
    next_sync_run  = {sync_run[1:0], run_stop_toggle_line};
    next_sync_wait = {sync_wait[1:0], wait_n};
    next_run_filt  = run_filt;
    next_wait_filt = wait_filt;
    if (sync_run[1] == sync_run[2])
    begin
      next_run_filt = sync_run[2];
    end
    if (sync_wait[1] == sync_wait[2])
    begin
      next_wait_filt = sync_wait[2];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync_run  <= `RHW_SYNC_RESET;
      sync_wait <= `RHW_SYNC_RESET;
      run_filt  <= 1'b1;
      wait_filt <= 1'b1;
    end
    else
    begin
      sync_run  <= next_sync_run;
      sync_wait <= next_sync_wait;
      run_filt  <= next_run_filt;
      wait_filt <= next_wait_filt;
    end
  end

  // Toggle line: only the low-to-high change counts, never the level; wait is used as a level
  assign run_edge = next_run_filt & ~run_filt;
  assign wait_low = ~wait_filt;

  ////////////////////////////////////////////////////////////////
  // Post-reset guard

  logic [3:0] guard_cnt;
  logic [3:0] next_guard_cnt;
  logic       guard_done;

  assign guard_done = (guard_cnt == `RHW_GUARD_CLKS);

  always_comb
  begin
    next_guard_cnt = guard_cnt;
    if (!guard_done)
    begin
      next_guard_cnt = guard_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      guard_cnt <= 4'h0;
    end
    else
    begin
      guard_cnt <= next_guard_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Run flip-flop and cycle sequencer

  rhw_pkg::cyc_state_t state;
  rhw_pkg::cyc_state_t next_state;
  logic                run_ff;
  logic                pend_tog;
  logic                tog_taken;
  logic                last_flag;
  logic                halt_req;
  logic                first_cyc;
  logic                next_run_ff;
  logic                next_pend_tog;
  logic                next_tog_taken;
  logic                next_last_flag;
  logic                next_halt_req;
  logic                next_first_cyc;
  logic                next_cycle_end;
  logic                stop_hit;
  logic                cyc_done;
  logic                ins_end;

  assign stop_hit = core_req.exec_valid
                  & (core_req.exec_opcode == `RHW_STOP_OPCODE);

  always_comb
  begin
    next_state     = state;
    next_run_ff    = run_ff;
    next_pend_tog  = pend_tog | (run_edge & guard_done);
    next_tog_taken = tog_taken;
    next_last_flag = last_flag;
    next_halt_req  = halt_req | stop_hit;
    next_first_cyc = first_cyc;
    cyc_done       = 1'b0;
    case (state)
      rhw_pkg::ST_IDLE:
      begin
        // Halted: nothing fetched until a toggle arrives
        if (pend_tog)
        begin
          next_run_ff    = 1'b1;
          next_pend_tog  = run_edge & guard_done;
          next_first_cyc = 1'b1;
          next_state     = rhw_pkg::ST_T1;
        end
      end
      rhw_pkg::ST_T1:
      begin
        next_last_flag = core_req.last_cycle;
        if (core_req.last_cycle)
        begin
          next_tog_taken = pend_tog;
          next_pend_tog  = run_edge & guard_done;
        end
        next_state = rhw_pkg::ST_T2;
      end
      rhw_pkg::ST_T2:
      begin
        if (!wait_low)
        begin
          next_state = rhw_pkg::ST_T3;
        end
      end
      rhw_pkg::ST_T3:
      begin
        next_state = rhw_pkg::ST_T4;
      end
      rhw_pkg::ST_T4:
      begin
        next_state = rhw_pkg::ST_T5;
      end
      rhw_pkg::ST_T5:
      begin
        if (core_req.cycle_write)
        begin
          next_state = rhw_pkg::ST_T6;
        end
        else
        begin
          cyc_done = 1'b1;
        end
      end
      rhw_pkg::ST_T6:
      begin
        if (!wait_low)
        begin
          cyc_done = 1'b1;
        end
      end
      default:
      begin
        next_state = rhw_pkg::ST_IDLE;
      end
    endcase
    next_first_cyc = next_first_cyc & ~cyc_done;
    if (cyc_done)
    begin
      next_state = rhw_pkg::ST_T1;
      if (last_flag)
      begin
        // Stop instruction wins over a toggle at the same end
        next_run_ff    = (halt_req | stop_hit) ? 1'b0 : run_ff ^ tog_taken;
        next_halt_req  = 1'b0;
        next_tog_taken = 1'b0;
        next_first_cyc = 1'b1;
        if (!next_run_ff)
        begin
          next_state = rhw_pkg::ST_IDLE;
        end
      end
    end
    next_cycle_end = cyc_done;
  end

  assign ins_end = cyc_done & last_flag;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state     <= rhw_pkg::ST_IDLE;
      run_ff    <= 1'b0;
      pend_tog  <= 1'b0;
      tog_taken <= 1'b0;
      last_flag <= 1'b0;
      halt_req  <= 1'b0;
      first_cyc <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      run_ff    <= next_run_ff;
      pend_tog  <= next_pend_tog;
      tog_taken <= next_tog_taken;
      last_flag <= next_last_flag;
      halt_req  <= next_halt_req;
      first_cyc <= next_first_cyc;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output flops

  rhw_pkg::bus_ctl_t next_bus_ctl;

  always_comb
  begin
    next_bus_ctl.input_transfer_strobe  = (next_state == rhw_pkg::ST_T2);
    next_bus_ctl.output_transfer_strobe = (next_state == rhw_pkg::ST_T6);
    next_bus_ctl.write_drive_en         = (next_state == rhw_pkg::ST_T6);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cycle_state <= rhw_pkg::ST_IDLE;
      bus_ctl     <= '0;
      run_ind     <= 1'b0;
      ifetch      <= 1'b0;
      cycle_end   <= 1'b0;
    end
    else
    begin
      cycle_state <= next_state;
      bus_ctl     <= next_bus_ctl;
      run_ind     <= next_run_ff;
      ifetch      <= next_first_cyc & (next_state != rhw_pkg::ST_IDLE);
      cycle_end   <= next_cycle_end;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks

  logic read_seen;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      read_seen <= 1'b0;
    end
    else if (state == rhw_pkg::ST_T1)
    begin
      read_seen <= 1'b0;
    end
    else if (state == rhw_pkg::ST_T2)
    begin
      read_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_toggle_starts;
    (state == rhw_pkg::ST_IDLE) && pend_tog |=> run_ind && (cycle_state == rhw_pkg::ST_T1);
  endproperty
  a_toggle_starts: assert property (p_toggle_starts)
    else $error("halted block ignored a pending toggle");

  property p_stop_halts;
    ins_end && (halt_req || stop_hit) |=> !run_ind && (cycle_state == rhw_pkg::ST_IDLE);
  endproperty
  a_stop_halts: assert property (p_stop_halts)
    else $error("stop instruction did not halt");

  property p_idle_low;
    (cycle_state == rhw_pkg::ST_IDLE) |-> !run_ind && !ifetch;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("run indicator high while halted");

  property p_read_wait;
    (state == rhw_pkg::ST_T2) && wait_low |=> (state == rhw_pkg::ST_T2) && bus_ctl.input_transfer_strobe;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read left data state while wait low");

  property p_write_wait;
    (state == rhw_pkg::ST_T6) && wait_low |=> (state == rhw_pkg::ST_T6) && bus_ctl.write_drive_en;
  endproperty
  a_write_wait: assert property (p_write_wait)
    else $error("write hold ended while wait low");

  property p_read_release;
    (state == rhw_pkg::ST_T2) && !wait_low |=> (state == rhw_pkg::ST_T3) ##1 (state == rhw_pkg::ST_T4) ##1 (state == rhw_pkg::ST_T5);
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("cycle did not advance after wait release");

  property p_no_write_skip;
    (state == rhw_pkg::ST_T5) && !core_req.cycle_write |=> (state != rhw_pkg::ST_T6) && cycle_end;
  endproperty
  a_no_write_skip: assert property (p_no_write_skip)
    else $error("write hold entered without a write");

  property p_write_after_read;
    bus_ctl.output_transfer_strobe |-> read_seen;
  endproperty
  a_write_after_read: assert property (p_write_after_read)
    else $error("write strobe without read strobe");

  property p_guard;
    !guard_done |-> !next_pend_tog;
  endproperty
  a_guard: assert property (p_guard)
    else $error("toggle taken inside reset guard");

endmodule

// ==== hdl/rhw_cfg.svh ====
// Constants for the run/stop and wait-state control block
// How it works
// - Act on rising edge of toggle line
// - Each recognised pulse inverts the run flip-flop
// - Stop instruction 7402 octal forces halt
// - Run indicator low while halted, high running
// - Pulse while halted starts running until the next pulse or a stop
// - Sample wait only in data transfer states
// - Low wait stretches transfer while it stays low
// - Read waits in read data state
// - Write waits in write hold, data driven
// - Stretch only in whole clock periods
// - Every write strobe follows a read strobe
// - No write: skip write hold, no sampling
// - Cycle is five states plus optional sixth
// - Toggle request sampled at T1 of last cycle
`ifndef RHW_CFG_SVH
`define RHW_CFG_SVH

// Stop instruction code, 7402 octal
`define RHW_STOP_OPCODE   12'hF02
// Clocks after reset before a toggle edge counts
`define RHW_GUARD_CLKS    4'hA
// Pin synchroniser reset value, lines idle high
`define RHW_SYNC_RESET    3'h7

`endif

// ==== hdl/rhw_pkg.sv ====
// Types for the run/stop and wait-state control block
package rhw_pkg;

  // Processor cycle states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_T1   = 7'h02,
    ST_T2   = 7'h04,
    ST_T3   = 7'h08,
    ST_T4   = 7'h10,
    ST_T5   = 7'h20,
    ST_T6   = 7'h40
  } cyc_state_t;

  // Cycle information from the instruction sequencer
  typedef struct packed {
    logic        cycle_write;
    logic        last_cycle;
    logic        exec_valid;
    logic [11:0] exec_opcode;
  } core_req_t;

  // Transfer strobes toward the multiplexed bus
  typedef struct packed {
    logic input_transfer_strobe;
    logic output_transfer_strobe;
    logic write_drive_en;
  } bus_ctl_t;

endpackage

// ==== tb/wait_partner.sv ====
// Far-side wait generator for memory and peripherals
module wait_partner (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Bench control
  input  wire logic              en,
  input  wire logic [3:0]        dly,
  // Bus side
  input  wire rhw_pkg::bus_ctl_t bus_ctl,
  output logic                   wait_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic       stb;

  assign stb = bus_ctl.input_transfer_strobe | bus_ctl.output_transfer_strobe;

  // Clocks since a strobe rose
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      cnt <= 4'h0;
    else if (!stb)
      cnt <= 4'h0;
    else if (cnt != 4'hF)
      cnt <= cnt + 4'h1;

  // With en high, low by default, released dly clocks into either strobe; with en low, always high
  // Release is a two-clock pulse, so wait is low again before write hold
  assign wait_n = !en | (stb & (cnt >= dly) & (cnt < dly + 4'h2));
  // Read waits and write waits both come from the strobe release
  logic unused_modes;
  assign unused_modes = 1'b0;
endmodule

// ==== tb/run_halt_wait_ctl_tb.sv ====
// Self-checking bench for the run/stop and wait-state control block
module run_halt_wait_ctl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clk_sys = 1'b0;
  logic                rst = 1'b1;
  logic                tgl = 1'b1;
  logic                en = 1'b0;
  logic [3:0]          dly = 4'h2;
  logic                wait_n;
  rhw_pkg::core_req_t  core_req = '0;
  rhw_pkg::cyc_state_t cycle_state;
  rhw_pkg::bus_ctl_t   bus_ctl;
  logic                run_ind, ifetch, cycle_end;
  logic                stop_now = 1'b0, may_halt = 1'b1, done_wr = 1'b0;
  logic [1:0]          prog[$];
  logic [1:0]          nxt;
  int                  num_errors = 0, n_compared = 0, n_cyc = 0;
  int                  n_all = 0, n_t2 = 0, n_t6 = 0, n_fetch = 0, nf, ph;

  always #25 clk_sys = ~clk_sys;

  run_halt_wait_ctl u_dut (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .run_stop_toggle_line (tgl),
    .wait_n               (wait_n),
    .core_req             (core_req),
    .cycle_state          (cycle_state),
    .bus_ctl              (bus_ctl),
    .run_ind              (run_ind),
    .ifetch               (ifetch),
    .cycle_end            (cycle_end)
  );

  wait_partner u_wait (
    .clk_sys (clk_sys),
    .rst     (rst),
    .en      (en),
    .dly     (dly),
    .bus_ctl (bus_ctl),
    .wait_n  (wait_n)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (num_errors == 0 && n_compared != 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Idle-high line pulsed low
  task automatic pulse(input int lo);
    @(posedge clk_sys) tgl <= 1'b0;
    repeat (lo) @(posedge clk_sys);
    tgl <= 1'b1;
  endtask

  task automatic wait_run(input logic exp);
    int i;
    for (i = 0; i < 400 && run_ind !== exp; i++)
      @(negedge clk_sys);
    chk(run_ind, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Sequencer side: queue head is the current cycle
  always @(posedge clk_sys)
  begin
    core_req.exec_valid  <= stop_now | 1'($urandom);
    core_req.exec_opcode <= stop_now ? 12'hF02 : {1'b0, 11'($urandom)};
    stop_now = 1'b0;
    if (cycle_state == rhw_pkg::ST_T5)
    begin
      done_wr = core_req.cycle_write;
      if (prog.size() != 0)
        void'(prog.pop_front());
    end
    if (cycle_state == rhw_pkg::ST_T5 || cycle_state == rhw_pkg::ST_IDLE)
    begin
      nxt = (prog.size() != 0) ? prog[0] : 2'($urandom);
      core_req.cycle_write <= nxt[1];
      core_req.last_cycle  <= nxt[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cycle monitor
  always @(negedge clk_sys)
  begin
    if (!rst)
    begin
      if (cycle_state == rhw_pkg::ST_IDLE || cycle_state == rhw_pkg::ST_T1)
      begin
        chk(cycle_end, n_all != 0);
        if (n_all != 0)
        begin
          chk(n_all, 4 + n_t2 + n_t6);
          chk(n_t6 != 0, done_wr);
          if (en)
          begin
            chk(n_t2 > dly && n_t2 <= dly + 5, 1'b1);
            if (done_wr)
              chk(n_t6 > dly && n_t6 <= dly + 5, 1'b1);
          end
          else
            chk(n_t2 + n_t6, 1 + done_wr);
        end
        n_all = 0;
        n_t2 = 0;
        n_t6 = 0;
      end
      if (cycle_state == rhw_pkg::ST_IDLE)
        chk({run_ind, ifetch, may_halt}, 3'h1);
      else
      begin
        chk(run_ind, 1'b1);
        n_all++;
      end
      if (cycle_state == rhw_pkg::ST_T1 && ifetch === 1'b1)
        n_fetch++;
      if (cycle_state == rhw_pkg::ST_T2)
      begin
        n_t2++;
        chk({bus_ctl.input_transfer_strobe, bus_ctl.output_transfer_strobe}, 2'h2);
      end
      if (cycle_state == rhw_pkg::ST_T6)
      begin
        n_t6++;
        chk({bus_ctl.write_drive_en, n_t2 != 0}, 2'h3);
      end
    end
  end

  always @(posedge clk_sys)
  begin
    n_cyc++;
    if (n_cyc == 30000)
    begin
      num_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h0372));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    pulse(3);
    repeat (14) @(negedge clk_sys);
    chk(run_ind, 1'b0);
    @(posedge clk_sys) tgl <= 1'b0;
    repeat (12) @(negedge clk_sys);
    chk(run_ind, 1'b0);
    @(posedge clk_sys) tgl <= 1'b1;
    wait_run(1'b1);
    for (ph = 1; ph < 7; ph++)
    begin
      may_halt = 1'b0;
      repeat (300) @(posedge clk_sys);
      @(negedge clk_sys);
      may_halt = 1'b1;
      if (ph[1])
        stop_now = 1'b1;
      else
        pulse(3);
      wait_run(1'b0);
      @(posedge clk_sys);
      en <= ~en;
      dly <= 4'($urandom_range(6, 1));
      pulse(3);
      wait_run(1'b1);
    end
    @(negedge clk_sys);
    stop_now = 1'b1;
    wait_run(1'b0);
    // Single step over a four-cycle instruction
    prog = '{2'h0, 2'h0, 2'h0, 2'h1};
    nf = n_fetch;
    pulse(3);
    wait_run(1'b1);
    pulse(3);
    wait_run(1'b0);
    chk(n_fetch - nf, 1);
    results();
  end
endmodule
